//--- src/smwd_window_decode.sv
// Register file and routing decode for the two secondary memory windows
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "smwd_params.svh"

// What this block does
// - An access inside the non-prefetchable window is routed to the secondary bus.
// - An access inside the prefetchable window is routed to the secondary bus.
// - Base and limit bits 15:4 are writable and hold address bits 31:20 for the compare.
// - Base and limit bits 3:0 read as zero and ignore writes.
// - A base is compared as if address bits 19:0 were zero.
// - A limit is compared as if address bits 19:0 were all ones.
// - The limit sets the top of each window and the base sets its bottom.
module smwd_window_decode (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire smwd_pkg::smwd_wb_req_type wb_req,
    output smwd_pkg::smwd_wb_rsp_type wb_rsp,
    input wire smwd_pkg::smwd_access_type access,
    output smwd_pkg::smwd_route_type route
);
    import smwd_pkg::*;

    smwd_state_type state_reg;
    smwd_state_type state_next;
    logic np_open;
    logic np_hit;
    logic pf_open;
    logic pf_hit;
    logic bus_req;
    logic wr_commit;

    // ======================================================================
    // Elaboration check
    // Field width must equal the count of decoded address bits
    if (`SMWD_FIELD_MSB - `SMWD_FIELD_LSB != `SMWD_ADDR_MSB - `SMWD_ADDR_LSB) begin : g_width_check
        $error("Field width does not match the decoded address bits");
    end

    // ======================================================================
    // Window comparators
    // non-prefetchable window
    smwd_window_match u_np_match (
        .base_field(state_reg.np_base),
        .limit_field(state_reg.np_limit),
        .addr(access.addr),
        .open(np_open),
        .hit(np_hit)
    );

    smwd_window_match u_pf_match (
        .base_field(state_reg.pf_base),
        .limit_field(state_reg.pf_limit),
        .addr(access.addr),
        .open(pf_open),
        .hit(pf_hit)
    );

    // ======================================================================
    // Bus helpers
    // Write lands on the edge where the master sees ack, never earlier
    assign bus_req = wb_req.cyc && wb_req.stb;
    assign wr_commit = bus_req && wb_req.we && state_reg.ack;

    // Bus byte address of a register offset
    function automatic logic [9:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'b00, idx};
    endfunction

    // Read word of a base or limit field; low nibble is always zero
    function automatic logic [31:0] field_word(input logic [11:0] field);
        field_word = {16'h0000, field, 4'h0};
    endfunction

    // Byte-lane update of a field; lane 0 only reaches bits 7:4
    function automatic logic [11:0] field_write(input logic [11:0] field,
                                                input logic [3:0] sel,
                                                input logic [31:0] dat);
        logic [11:0] result;
        result = field;
        if (sel[0]) begin
            result[3:0] = dat[7:4];
        end
        if (sel[1]) begin
            result[11:4] = dat[15:8];
        end
        field_write = result;
    endfunction

    // ======================================================================
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        // Ack once per request, dropped the cycle after it was given
        state_next.ack = bus_req && !state_reg.ack;
        // Read data captured with ack so it stands while ack is high
        if (bus_req && !state_reg.ack) begin
            if (wb_req.adr == reg_addr(`SMWD_IDX_NP_BASE)) begin
                state_next.rdata = field_word(state_reg.np_base);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_NP_LIMIT)) begin
                state_next.rdata = field_word(state_reg.np_limit);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_PF_BASE)) begin
                state_next.rdata = field_word(state_reg.pf_base);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_PF_LIMIT)) begin
                state_next.rdata = field_word(state_reg.pf_limit);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_STATUS)) begin
                state_next.rdata = 32'h00000000;
                state_next.rdata[`SMWD_ST_NP_OPEN] = np_open;
                state_next.rdata[`SMWD_ST_PF_OPEN] = pf_open;
                state_next.rdata[`SMWD_ST_NP_LAST] = state_reg.route.nonprefetch;
                state_next.rdata[`SMWD_ST_PF_LAST] = state_reg.route.prefetch;
            end else begin
                state_next.rdata = 32'h00000000;
            end
        end
        if (wr_commit) begin
            if (wb_req.adr == reg_addr(`SMWD_IDX_NP_BASE)) begin
                state_next.np_base = field_write(state_reg.np_base, wb_req.sel, wb_req.dat);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_NP_LIMIT)) begin
                state_next.np_limit = field_write(state_reg.np_limit, wb_req.sel, wb_req.dat);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_PF_BASE)) begin
                state_next.pf_base = field_write(state_reg.pf_base, wb_req.sel, wb_req.dat);
            end else if (wb_req.adr == reg_addr(`SMWD_IDX_PF_LIMIT)) begin
                state_next.pf_limit = field_write(state_reg.pf_limit, wb_req.sel, wb_req.dat);
            end
        end
        state_next.route.valid = access.valid;
        state_next.route.nonprefetch = access.valid && np_hit;
        state_next.route.prefetch = access.valid && pf_hit;
    end

    // ======================================================================
    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.np_base <= 12'hFFF;
            state_reg.np_limit <= 12'h000;
            state_reg.pf_base <= 12'hFFF;
            state_reg.pf_limit <= 12'h000;
            state_reg.ack <= 1'b0;
            state_reg.rdata <= 32'h00000000;
            state_reg.route <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign wb_rsp.ack = state_reg.ack;
    assign wb_rsp.dat = state_reg.rdata;
    assign route = state_reg.route;

    // ======================================================================
    // Checks
    AST_NP_FORWARD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && access.addr >= {state_reg.np_base, 20'h00000}
        && access.addr <= {state_reg.np_limit, 20'hFFFFF}
        |=> route.nonprefetch)
        else $error("Access inside non-prefetchable window not forwarded");

    AST_PF_FORWARD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && access.addr >= {state_reg.pf_base, 20'h00000}
        && access.addr <= {state_reg.pf_limit, 20'hFFFFF}
        |=> route.prefetch && route.valid)
        else $error("Access inside prefetchable window not forwarded");

    AST_FIELD_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_commit && wb_req.sel[1:0] == 2'b11 && wb_req.adr == reg_addr(`SMWD_IDX_PF_LIMIT)
        |=> state_reg.pf_limit == $past(wb_req.dat[15:4]))
        else $error("Prefetchable limit field did not take written bits");

    AST_LOW_NIBBLE_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wb_rsp.ack && !wb_req.we |-> wb_rsp.dat[3:0] == 4'h0
        || wb_req.adr == reg_addr(`SMWD_IDX_STATUS))
        else $error("Read-only low nibble read back non-zero");

    AST_BASE_FLOOR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && np_open && access.addr[31:20] == state_reg.np_base
        && access.addr[19:0] == 20'h00000 ##1 !wr_commit[*1]
        |-> route.nonprefetch)
        else $error("Base boundary address missed");

    AST_LIMIT_TOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && np_open && access.addr[31:20] == state_reg.np_limit
        && access.addr[19:0] == 20'hFFFFF |=> route.nonprefetch)
        else $error("Top byte of limit block missed");

    AST_OUTSIDE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && (access.addr[31:20] < state_reg.pf_base
        || access.addr[31:20] > state_reg.pf_limit) |=> !route.prefetch)
        else $error("Access outside prefetchable window forwarded");

    AST_EMPTY_WINDOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && state_reg.np_base > state_reg.np_limit |=> !route.nonprefetch)
        else $error("Inverted non-prefetchable window matched");

    AST_ACK_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        bus_req && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
        else $error("Bus answer not a single-cycle ack");

    AST_NP_OUTSIDE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && (access.addr[31:20] < state_reg.np_base
        || access.addr[31:20] > state_reg.np_limit) |=> !route.nonprefetch)
        else $error("Access outside non-prefetchable window forwarded");

    AST_PF_EMPTY_WINDOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
        access.valid && state_reg.pf_base > state_reg.pf_limit |=> !route.prefetch)
        else $error("Inverted prefetchable window matched");

    AST_IDLE_NO_ROUTE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !access.valid |=> !route.valid && !route.nonprefetch && !route.prefetch)
        else $error("Route raised without an access");

    AST_LANE_KEEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_commit && !wb_req.sel[0] && wb_req.adr == reg_addr(`SMWD_IDX_NP_BASE)
        |=> state_reg.np_base[3:0] == $past(state_reg.np_base[3:0]))
        else $error("Disabled byte lane changed the base field");

endmodule

//--- src/smwd_params.svh
// Offsets, field positions, reset values and timing counts of the window decoder
`ifndef SMWD_PARAMS_SVH
`define SMWD_PARAMS_SVH

// ==========================================================================
// Register byte offsets; each register sits alone at its own bus byte address
`define SMWD_IDX_NP_BASE 8'h20
`define SMWD_IDX_NP_LIMIT 8'h22
`define SMWD_IDX_PF_BASE 8'h24
`define SMWD_IDX_PF_LIMIT 8'h26
`define SMWD_IDX_STATUS 8'h28

// ==========================================================================
// Field layout of the base and limit registers
`define SMWD_FIELD_MSB 15
`define SMWD_FIELD_LSB 4
`define SMWD_RO_MSB 3
`define SMWD_ADDR_MSB 31
`define SMWD_ADDR_LSB 20

// ==========================================================================
// Reset values
`define SMWD_BASE_RESET 16'hFFF0
`define SMWD_LIMIT_RESET 16'h0000

// ==========================================================================
// Status register bits
`define SMWD_ST_NP_OPEN 0
`define SMWD_ST_PF_OPEN 1
`define SMWD_ST_NP_LAST 2
`define SMWD_ST_PF_LAST 3

// ==========================================================================
// Timing: bus answer and decode result both come one cycle after the request
`define SMWD_ACK_DELAY 1
`define SMWD_DECODE_DELAY 1

`endif

//--- src/smwd_pkg.sv
// Types and shared decode functions of the secondary memory window decoder
package smwd_pkg;

    // ======================================================================
    // Bus carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } smwd_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } smwd_wb_rsp_type;

    // ======================================================================
    // Processor access request and routing answer
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } smwd_access_type;

    typedef struct packed {
        logic valid;
        logic nonprefetch;
        logic prefetch;
    } smwd_route_type;

    // ======================================================================
    // Whole state of the main module
    typedef struct packed {
        logic [11:0] np_base;
        logic [11:0] np_limit;
        logic [11:0] pf_base;
        logic [11:0] pf_limit;
        logic ack;
        logic [31:0] rdata;
        smwd_route_type route;
    } smwd_state_type;

    // ======================================================================
    // Base field widened to a full address, low bits zero
    // base bits zero
    function automatic logic [31:0] smwd_base_addr(input logic [11:0] field);
        smwd_base_addr = {field, 20'h00000};
    endfunction

    // Limit field widened to a full address, low bits all ones
    // limit bits ones
    function automatic logic [31:0] smwd_limit_addr(input logic [11:0] field);
        smwd_limit_addr = {field, 20'hFFFFF};
    endfunction

endpackage

//--- src/smwd_window_match.sv
// One inclusive address window built from a base field and a limit field
`timescale 1ns/100ps
module smwd_window_match (
    input wire logic [11:0] base_field,
    input wire logic [11:0] limit_field,
    input wire logic [31:0] addr,
    output logic open,
    output logic hit
);
    import smwd_pkg::*;

    // ======================================================================
    // Window compare
    // Full 32-bit compare keeps the 1 MB rounding explicit in one place
    always_comb begin
        open = smwd_base_addr(base_field) <= smwd_limit_addr(limit_field);
        hit = open && (addr >= smwd_base_addr(base_field))
            && (addr <= smwd_limit_addr(limit_field));
    end

endmodule

//--- testbench/smwd_cpu_model.sv
// Processor-side model that issues memory accesses to the window decoder
`timescale 1ns/100ps
module smwd_cpu_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req,
    input wire logic [31:0] req_addr,
    output smwd_pkg::smwd_access_type access
);
    import smwd_pkg::*;
    // ======================================================================
    // Access launch
    // Idle address shows the inverse of the last one, so a stale value never helps
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            access <= '0;
        end else begin
            access.valid <= req;
            access.addr <= req ? req_addr : ~access.addr;
        end
    end
endmodule

//--- testbench/test_secondary_memory_window_decode.sv
// Self-checking bench of the secondary memory window decoder
`timescale 1ns/100ps
module test_secondary_memory_window_decode;
    import smwd_pkg::*;
    logic sys_clk;
    logic reset_n;
    logic req;
    logic [31:0] req_addr;
    logic [31:0] rd;
    logic [3:0] wb_sel;
    smwd_wb_req_type wb_req;
    smwd_wb_rsp_type wb_rsp;
    smwd_access_type access;
    smwd_route_type route;
    int err_count;
    int checked;
    int cycles;

    smwd_window_decode uut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .access(access), .route(route));
    smwd_cpu_model cpu (.sys_clk(sys_clk), .reset_n(reset_n), .req(req),
        .req_addr(req_addr), .access(access));

    // ======================================================================
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ======================================================================
    // Bus and access drivers
    // One classic cycle; only the global timeout ends the wait for ack
    task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] wd);
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: wb_sel, adr: adr, dat: wd};
        do @(posedge sys_clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge sys_clk);
    endtask

    // Route answer lands two edges after the request reaches the model
    task automatic probe(input logic [31:0] a, input logic np, input logic pf);
        @(posedge sys_clk);
        req <= 1'b1;
        req_addr <= a;
        @(posedge sys_clk);
        req <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({route.valid, route.nonprefetch, route.prefetch}, {1'b1, np, pf});
    endtask

    // ======================================================================
    // Scenarios
    // Status read whose request cycle sees the route of an access at address a
    task automatic status_read(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        req <= 1'b1;
        req_addr <= a;
        @(posedge sys_clk);
        req <= 1'b0;
        wb(1'b0, 10'h028, 32'h0);
        chk(rd, exp);
    endtask

    task automatic reset_values;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 10'h020 + 10'(2 * i), 32'h0);
            chk(rd, i[0] ? 32'h0 : 32'h0000FFF0);
        end
        probe(32'h00000000, 1'b0, 1'b0);
        probe(32'hFFF00000, 1'b0, 1'b0);
        status_read(32'h00000000, 32'h00000000);
    endtask

    task automatic field_access;
        wb(1'b1, 10'h020, 32'hFFFFFFFF);
        wb(1'b0, 10'h020, 32'h0);
        chk(rd, 32'h0000FFF0);
        // Single byte lanes leave the other half of the field alone
        wb_sel = 4'h2;
        wb(1'b1, 10'h020, 32'h0000AB00);
        wb_sel = 4'h1;
        wb(1'b1, 10'h020, 32'h00000050);
        wb_sel = 4'hF;
        wb(1'b0, 10'h020, 32'h0);
        chk(rd, 32'h0000AB50);
        wb(1'b1, 10'h022, 32'h0000000F);
        wb(1'b0, 10'h022, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b1, 10'h3FC, 32'h12345678);
        wb(1'b0, 10'h3FC, 32'h0);
        chk(rd, 32'h00000000);
    endtask

    // Windows set up before use and kept apart from each other
    // software duty
    task automatic np_window;
        wb(1'b1, 10'h020, 32'h0000123F);
        wb(1'b1, 10'h022, 32'h0000125A);
        probe(32'h122FFFFF, 1'b0, 1'b0);
        probe(32'h12300000, 1'b1, 1'b0);
        probe(32'h125FFFFF, 1'b1, 1'b0);
        probe(32'h12600000, 1'b0, 1'b0);
        status_read(32'h12400000, 32'h00000005);
    endtask

    task automatic pf_window;
        wb(1'b1, 10'h024, 32'h0000800F);
        wb(1'b1, 10'h026, 32'h00008000);
        wb(1'b0, 10'h024, 32'h0);
        chk(rd, 32'h00008000);
        probe(32'h7FFFFFFF, 1'b0, 1'b0);
        probe(32'h80000000, 1'b0, 1'b1);
        probe(32'h800FFFFF, 1'b0, 1'b1);
        probe(32'h80100000, 1'b0, 1'b0);
        status_read(32'h80000000, 32'h0000000B);
    endtask

    task automatic empty_window;
        wb(1'b1, 10'h024, 32'h00009000);
        probe(32'h80000000, 1'b0, 1'b0);
        probe(32'h90000000, 1'b0, 1'b0);
        probe(32'h12400000, 1'b1, 1'b0);
        status_read(32'h90000000, 32'h00000001);
    endtask

    // Reset in mid-run puts both windows back to empty
    task automatic mid_reset;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        wb(1'b0, 10'h020, 32'h0);
        chk(rd, 32'h0000FFF0);
        wb(1'b0, 10'h022, 32'h0);
        chk(rd, 32'h00000000);
        probe(32'h12400000, 1'b0, 1'b0);
    endtask

    // ======================================================================
    // Clock, timeout and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        reset_n = 1'b0;
        req = 1'b0;
        req_addr = '0;
        wb_req = '0;
        wb_sel = 4'hF;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        reset_values();
        field_access();
        np_window();
        pf_window();
        empty_window();
        mid_reset();
        end_sim();
    end
endmodule
